// [design/mps_blink_div.sv]
/*
 * mps_blink_div: divider that emits a one-cycle enable every HALF_CYC clocks while run is high.
 * Assumes HALF_CYC fits in BLINK_W bits and is at least two.
 */
`timescale 1ns/100ps
module mps_blink_div
    import mps_pkg::*;
#(
    parameter logic [BLINK_W-1:0] HALF_CYC = BLINK_W'(BLINK_HALF_CYC)
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic run,
    output logic      tick
);

    mps_div_t div_reg;
    mps_div_t div_next;

    always_comb begin
        div_next      = div_reg;
        div_next.tick = 1'b0;
        if (!run) begin
            // restart so the first flash after enable has full length
            div_next.cnt = '0;
        end else if (div_reg.cnt >= HALF_CYC - BLINK_W'(1)) begin
            div_next.cnt  = '0;
            div_next.tick = 1'b1;
        end else begin
            div_next.cnt = div_reg.cnt + BLINK_W'(1);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    assign tick = div_reg.tick;

    a_tick_spacing : assert property (@(posedge sys_clk) disable iff (rst)
        tick |=> !tick)
        else $error("divider tick lasted more than one cycle");

endmodule

// [design/mps_pkg.sv]
/*
 * mps_pkg: shared types, states and timing constants for the modem power sequencer.
 * Assumes a single 20 MHz system clock; all times are turned into cycle counts here.
 */
package mps_pkg;

    localparam int unsigned CLK_PERIOD_NS   = 50;

    // time from power request to cpu reset release
    localparam int unsigned RESET_DELAY_NS  = 100000;
    localparam int unsigned RESET_DELAY_CYC = (RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // width of the boot-time clear-to-send pulse
    localparam int unsigned CTS_PULSE_NS    = 2000;
    localparam int unsigned CTS_PULSE_CYC   = CTS_PULSE_NS / CLK_PERIOD_NS;

    // half period of the fast indicator flashing
    localparam int unsigned BLINK_HALF_MS   = 50;
    localparam int unsigned BLINK_HALF_CYC  = (BLINK_HALF_MS * 1000000) / CLK_PERIOD_NS;

    localparam int unsigned CNT_W           = 12;
    localparam int unsigned BLINK_W         = 20;

    typedef enum logic [3:0] {
        MPS_OFF        = 4'h0,
        MPS_RST_DELAY  = 4'h1,
        MPS_BOOT_CTS   = 4'h2,
        MPS_BOOT       = 4'h3,
        MPS_INIT       = 4'h4,
        MPS_READY      = 4'h5,
        MPS_SHUT_DEREG = 4'h6,
        MPS_SHUT_SAVE  = 4'h7,
        MPS_SHUT_DSR   = 4'h8,
        MPS_SHUT_RADIO = 4'h9,
        MPS_DOWN       = 4'hA
    } mps_state_t;

    // serial handshake lines, all active low
    typedef struct packed {
        logic cts_n;
        logic dsr_n;
        logic dcd_n;
    } mps_hs_t;

    // indicator drives, all active low
    typedef struct packed {
        logic batt_n;
        logic rx_n;
        logic tx_n;
    } mps_led_t;

    // requests to the modem firmware side
    typedef struct packed {
        logic dereg_req;
        logic save_req;
        logic flush_pulse;
    } mps_req_t;

    typedef struct packed {
        mps_state_t         st;
        logic [CNT_W-1:0]   cnt;
        logic               blink_ph;
        logic               cpu_reset_n;
        logic               radio_power_on;
        logic               host_if_en;
        logic               settings_saved;
        mps_hs_t            hs;
        mps_led_t           led;
        mps_req_t           req;
    } mps_core_t;

    typedef struct packed {
        logic [BLINK_W-1:0] cnt;
        logic               tick;
    } mps_div_t;

endpackage

// [design/mps_sequencer.sv]
/*
 * mps_sequencer: power-up and soft power-down sequencer of the data modem module.
 * Assumes all inputs are synchronous to sys_clk; firmware progress arrives as level inputs.
 */
`timescale 1ns/100ps

// Overview of operation
// RULE_01 - host supplies the power rail first, then raises the power request.
// RULE_02 - cpu reset comes from supply detector plus a fixed reset delay.
// RULE_03 - host forced reset holds the cpu; initialisation starts after release.
// RULE_04 - right after reset release, clear-to-send pulses briefly low then high.
// RULE_05 - command and serial interfaces enable only after initialisation completes.
// RULE_06 - after initialisation, data-set-ready asserts, then terminal and network setup start.
// RULE_07 - clear-to-send asserts only once the terminal interface has initialised.
// RULE_08 - carrier detect asserts only after network acknowledges registration.
// RULE_09 - forced reset, handshakes, indicators and cpu reset are all active low.
// RULE_10 - serial shutdown command alone never powers down; power request must drop.
// RULE_11 - soft shutdown starts when the power request is deasserted.
// RULE_12 - shutdown order: deregister and drop carrier, save, then drop data-set-ready.
// RULE_13 - host keeps the rail up to ten seconds after dropping the request.
// RULE_14 - battery indicator flashes fast during shutdown steps and stops afterwards.
// RULE_15 - after deregistration the radio supply enable is deasserted.
// RULE_16 - once data-set-ready drops, host may cut power; saved settings persist.
// RULE_17 - forced reset after shutdown gives a cold start that discards saved settings.
// RULE_18 - all indicators flash at startup; receive and transmit flash at power down.
module mps_sequencer
    import mps_pkg::*;
#(
    parameter int unsigned BLINK_CYC = BLINK_HALF_CYC
) (
    input  wire logic     sys_clk,
    input  wire logic     rst,
    input  wire logic     supply_ok,
    input  wire logic     host_power_request,
    input  wire logic     host_forced_reset_n,
    input  wire logic     boot_done,
    input  wire logic     init_done,
    input  wire logic     dte_init_done,
    input  wire logic     net_reg_ack,
    input  wire logic     dereg_done,
    input  wire logic     save_done,
    output logic          cpu_reset_n,
    output logic          radio_power_on,
    output logic          host_if_en,
    output logic          settings_saved,
    output mps_hs_t       hs,
    output mps_led_t      led,
    output mps_req_t      req
);

    mps_core_t core_reg;
    mps_core_t core_next;
    logic      blink_tick;
    logic      blink_run;
    logic      starting;
    logic      stopping;

    assign starting  = core_reg.st inside {MPS_RST_DELAY, MPS_BOOT_CTS, MPS_BOOT, MPS_INIT};
    assign stopping  = core_reg.st inside {MPS_SHUT_DEREG, MPS_SHUT_SAVE, MPS_SHUT_DSR};
    assign blink_run = starting | stopping;

    mps_blink_div #(
        .HALF_CYC (BLINK_W'(BLINK_CYC))
    ) u_blink (
        .sys_clk (sys_clk),
        .rst     (rst),
        .run     (blink_run),
        .tick    (blink_tick)
    );

    always_comb begin
        core_next                 = core_reg;
        core_next.req.flush_pulse = 1'b0;
        if (blink_tick) begin
            core_next.blink_ph = ~core_reg.blink_ph;
        end

        if (!supply_ok) begin
            // detector holds all in reset; saved settings survive [RULE_02] [RULE_16]
            core_next.st             = MPS_OFF;
            core_next.cnt            = '0;
            core_next.cpu_reset_n    = 1'b0;
            core_next.radio_power_on = 1'b0;
            core_next.host_if_en     = 1'b0;
            core_next.hs             = '1;
            core_next.req.dereg_req  = 1'b0;
            core_next.req.save_req   = 1'b0;
        end else if (!host_forced_reset_n) begin
            // forced reset while powered; after shutdown a cold start [RULE_03] [RULE_17]
            if (core_reg.st == MPS_DOWN && core_reg.settings_saved) begin
                core_next.req.flush_pulse = 1'b1;
            end
            core_next.settings_saved = core_reg.st == MPS_DOWN ? 1'b0 : core_reg.settings_saved;
            core_next.st             = MPS_OFF;
            core_next.cnt            = '0;
            core_next.cpu_reset_n    = 1'b0;
            core_next.radio_power_on = 1'b0;
            core_next.host_if_en     = 1'b0;
            core_next.hs             = '1;
            core_next.req.dereg_req  = 1'b0;
            core_next.req.save_req   = 1'b0;
        end else begin
            case (core_reg.st)
                MPS_OFF, MPS_DOWN: begin
                    // only the power request starts, never a serial command [RULE_01] [RULE_10]
                    if (host_power_request) begin
                        core_next.st             = MPS_RST_DELAY;
                        core_next.cnt            = '0;
                        core_next.radio_power_on = 1'b1;
                    end
                end
                MPS_RST_DELAY: begin
                    if (core_reg.cnt >= CNT_W'(RESET_DELAY_CYC - 1)) begin
                        core_next.st          = MPS_BOOT_CTS;
                        core_next.cnt         = '0;
                        core_next.cpu_reset_n = 1'b1;          // [RULE_02]
                        core_next.hs.cts_n    = 1'b0;          // [RULE_04]
                    end else begin
                        core_next.cnt = core_reg.cnt + CNT_W'(1);
                    end
                end
                MPS_BOOT_CTS: begin
                    if (core_reg.cnt >= CNT_W'(CTS_PULSE_CYC - 1)) begin
                        core_next.st       = MPS_BOOT;
                        core_next.hs.cts_n = 1'b1;             // [RULE_04]
                    end else begin
                        core_next.cnt = core_reg.cnt + CNT_W'(1);
                    end
                end
                MPS_BOOT: begin
                    if (boot_done) begin
                        core_next.st = MPS_INIT;
                    end
                end
                MPS_INIT: begin
                    if (init_done) begin
                        core_next.st         = MPS_READY;
                        core_next.host_if_en = 1'b1;           // [RULE_05]
                        core_next.hs.dsr_n   = 1'b0;           // [RULE_06]
                    end
                end
                MPS_READY: begin
                    if (!host_power_request) begin
                        core_next.st            = MPS_SHUT_DEREG;  // [RULE_11]
                        core_next.req.dereg_req = 1'b1;
                    end else begin
                        if (dte_init_done) begin
                            core_next.hs.cts_n = 1'b0;         // [RULE_07]
                        end
                        if (net_reg_ack) begin
                            core_next.hs.dcd_n = 1'b0;         // [RULE_08]
                        end
                    end
                end
                MPS_SHUT_DEREG: begin
                    if (dereg_done) begin
                        core_next.st            = MPS_SHUT_SAVE;
                        core_next.req.dereg_req = 1'b0;
                        core_next.req.save_req  = 1'b1;
                        core_next.hs.dcd_n      = 1'b1;        // [RULE_12]
                    end
                end
                MPS_SHUT_SAVE: begin
                    if (save_done) begin
                        core_next.st             = MPS_SHUT_DSR;
                        core_next.req.save_req   = 1'b0;
                        core_next.settings_saved = 1'b1;       // [RULE_12]
                    end
                end
                MPS_SHUT_DSR: begin
                    core_next.st         = MPS_SHUT_RADIO;
                    core_next.hs         = '1;                 // [RULE_12]
                    core_next.host_if_en = 1'b0;
                end
                MPS_SHUT_RADIO: begin
                    core_next.st             = MPS_DOWN;
                    core_next.radio_power_on = 1'b0;           // [RULE_15]
                end
                default: begin
                    core_next.st = MPS_OFF;
                end
            endcase
        end

        // indicators: a low drive lights the lamp [RULE_09]
        core_next.led = '1;
        if (core_next.st inside {MPS_RST_DELAY, MPS_BOOT_CTS, MPS_BOOT, MPS_INIT}) begin
            core_next.led = {3{core_next.blink_ph}};           // [RULE_18]
        end else if (core_next.st inside {MPS_SHUT_DEREG, MPS_SHUT_SAVE, MPS_SHUT_DSR}) begin
            core_next.led.batt_n = core_next.blink_ph;         // [RULE_14]
            core_next.led.rx_n   = core_next.blink_ph;         // [RULE_18]
            core_next.led.tx_n   = core_next.blink_ph;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            core_reg             <= '0;
            core_reg.st          <= MPS_OFF;
            core_reg.hs          <= '1;
            core_reg.led         <= '1;
            core_reg.blink_ph    <= 1'b1;
        end else begin
            core_reg <= core_next;
        end
    end

    assign cpu_reset_n    = core_reg.cpu_reset_n;
    assign radio_power_on = core_reg.radio_power_on;
    assign host_if_en     = core_reg.host_if_en;
    assign settings_saved = core_reg.settings_saved;
    assign hs             = core_reg.hs;
    assign led            = core_reg.led;
    assign req            = core_reg.req;

    // checks kept next to the sequencing they guard
    a_supply_holds_rst : assert property (@(posedge sys_clk) disable iff (rst) // [RULE_02]
        !supply_ok |=> !cpu_reset_n && radio_power_on == 1'b0)
        else $error("cpu left reset without good supply");

    a_reset_delay_len : assert property (@(posedge sys_clk) disable iff (rst) // [RULE_02]
        $rose(cpu_reset_n) |-> $past(core_reg.cnt) == CNT_W'(RESET_DELAY_CYC - 1))
        else $error("reset delay has wrong length");

    a_forced_rst_hold : assert property (@(posedge sys_clk) disable iff (rst) // [RULE_03]
        !host_forced_reset_n |=> !cpu_reset_n && hs.dsr_n)
        else $error("cpu running under forced reset");

    a_boot_cts_pulse : assert property (@(posedge sys_clk) disable iff (rst) // [RULE_04]
        $rose(cpu_reset_n) |-> !hs.cts_n [*8])
        else $error("boot clear-to-send pulse missing or short");

    a_if_after_init : assert property (@(posedge sys_clk) disable iff (rst) // [RULE_05]
        $rose(host_if_en) |-> $past(init_done) && $fell(hs.dsr_n))
        else $error("interfaces enabled before initialisation");

    a_cts_after_dte : assert property (@(posedge sys_clk) disable iff (rst) // [RULE_07]
        $fell(hs.cts_n) && !hs.dsr_n |-> $past(dte_init_done))
        else $error("clear-to-send without terminal init");

    a_dcd_after_ack : assert property (@(posedge sys_clk) disable iff (rst) // [RULE_08]
        $fell(hs.dcd_n) |-> $past(net_reg_ack) && !hs.dsr_n)
        else $error("carrier detect before registration ack");

    a_shut_on_release : assert property (@(posedge sys_clk) disable iff (rst) // [RULE_11]
        core_reg.st == MPS_READY && !host_power_request && supply_ok && host_forced_reset_n
        |=> req.dereg_req)
        else $error("power request drop did not start shutdown");

    a_shut_order : assert property (@(posedge sys_clk) disable iff (rst) // [RULE_12]
        $rose(hs.dsr_n) && $past(supply_ok) && $past(host_forced_reset_n)
        |-> hs.dcd_n && settings_saved)
        else $error("ready dropped before deregistration and save");

    a_radio_after_dereg : assert property (@(posedge sys_clk) disable iff (rst) // [RULE_15]
        $fell(radio_power_on) && $past(supply_ok) && $past(host_forced_reset_n)
        |-> hs.dcd_n && hs.dsr_n)
        else $error("radio supply dropped before deregistration");

    a_batt_led_quiet : assert property (@(posedge sys_clk) disable iff (rst) // [RULE_14]
        core_reg.st inside {MPS_READY, MPS_DOWN, MPS_SHUT_RADIO} |-> led.batt_n)
        else $error("battery indicator lit outside shutdown");

    a_cold_start : assert property (@(posedge sys_clk) disable iff (rst) // [RULE_17]
        core_reg.st == MPS_DOWN && settings_saved && supply_ok && !host_forced_reset_n
        |=> req.flush_pulse && !settings_saved)
        else $error("forced reset after shutdown did not flush settings");

    // 40 cycles is the boot pulse width at the 20 MHz clock
    a_boot_pulse_end : assert property (@(posedge sys_clk) disable iff (rst) // [RULE_04]
        $rose(cpu_reset_n) |-> ##40 hs.cts_n)
        else $error("boot clear-to-send pulse did not end");

    a_if_drop_with_dsr : assert property (@(posedge sys_clk) disable iff (rst) // [RULE_05]
        $rose(hs.dsr_n) |-> !host_if_en)
        else $error("interfaces left enabled after ready dropped");

    a_dcd_needs_dsr : assert property (@(posedge sys_clk) disable iff (rst) // [RULE_08]
        !hs.dcd_n |-> !hs.dsr_n)
        else $error("carrier detect shown while not ready");

    a_save_after_dereg : assert property (@(posedge sys_clk) disable iff (rst) // [RULE_12]
        req.save_req |-> !req.dereg_req && hs.dcd_n)
        else $error("save requested before deregistration finished");

    a_flush_single : assert property (@(posedge sys_clk) disable iff (rst) // [RULE_17]
        req.flush_pulse |=> !req.flush_pulse)
        else $error("settings flush lasted more than one cycle");

    // all three lamps must flash in step while starting
    a_start_flash_all : assert property (@(posedge sys_clk) disable iff (rst) // [RULE_18]
        starting |-> led.batt_n == led.rx_n && led.rx_n == led.tx_n)
        else $error("indicators not flashing together at startup");

    c_power_up : cover property (@(posedge sys_clk) disable iff (rst)
        $fell(hs.dsr_n) ##[1:1000] $fell(hs.dcd_n));

    c_soft_down : cover property (@(posedge sys_clk) disable iff (rst)
        $rose(req.dereg_req) ##[1:1000] $fell(radio_power_on));

    c_cold_start : cover property (@(posedge sys_clk) disable iff (rst)
        req.flush_pulse);

    c_forced_hold : cover property (@(posedge sys_clk) disable iff (rst)
        !host_forced_reset_n && host_power_request && supply_ok);

    c_startup_flash : cover property (@(posedge sys_clk) disable iff (rst)
        starting && $fell(led.rx_n));

endmodule

// [tb/mps_host_model.sv]
/*
 * mps_host_model: host terminal that feeds the modem rail and drives power request and reset.
 * Assumes commands from the bench arrive synchronous to sys_clk; all outputs are registered.
 */
`timescale 1ns/100ps
module mps_host_model
    import mps_pkg::*;
(
    input  wire logic    sys_clk,
    input  wire logic    rst,
    input  wire logic    cmd_rail,
    input  wire logic    cmd_on,
    input  wire logic    cmd_reset,
    input  wire mps_hs_t hs,
    output logic         supply_ok,
    output logic         host_power_request,
    output logic         host_forced_reset_n
);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            supply_ok           <= 1'b0;
            host_power_request  <= 1'b0;
            host_forced_reset_n <= 1'b1;
        end else begin
            // rail stays while the modem still shows ready, so a save never loses power
            supply_ok           <= cmd_rail | (supply_ok & ~hs.dsr_n);
            // request only on a rail that is already up
            host_power_request  <= cmd_on & supply_ok;
            host_forced_reset_n <= ~cmd_reset;
        end
    end
endmodule

// [tb/testbench.sv]
/*
 * testbench: self-checking bench for mps_sequencer with a host model on the far side.
 * Assumes a 20 MHz clock; firmware progress inputs are pulsed by the bench for one cycle.
 */
`timescale 1ns/100ps
module testbench
    import mps_pkg::*;
;
    logic       sys_clk = 1'b0;
    logic       rst = 1'b1;
    logic       cmd_rail = 1'b0;
    logic       cmd_on = 1'b0;
    logic       cmd_reset = 1'b0;
    logic [5:0] fw_in = 6'h00;
    logic       supply_ok;
    logic       host_power_request;
    logic       host_forced_reset_n;
    logic       cpu_reset_n;
    logic       radio_power_on;
    logic       host_if_en;
    logic       settings_saved;
    mps_hs_t    hs;
    mps_led_t   led;
    mps_req_t   req;
    int         err_count = 0;
    int         total_checks = 0;

    always #25 sys_clk = ~sys_clk;

    mps_host_model HOST (
        .sys_clk(sys_clk), .rst(rst), .cmd_rail(cmd_rail), .cmd_on(cmd_on),
        .cmd_reset(cmd_reset), .hs(hs), .supply_ok(supply_ok),
        .host_power_request(host_power_request), .host_forced_reset_n(host_forced_reset_n)
    );

    // short blink period keeps flashing visible within a few cycles
    mps_sequencer #(.BLINK_CYC(4)) DUT (
        .sys_clk(sys_clk), .rst(rst), .supply_ok(supply_ok),
        .host_power_request(host_power_request), .host_forced_reset_n(host_forced_reset_n),
        .boot_done(fw_in[0]), .init_done(fw_in[1]), .dte_init_done(fw_in[2]),
        .net_reg_ack(fw_in[3]), .dereg_done(fw_in[4]), .save_done(fw_in[5]),
        .cpu_reset_n(cpu_reset_n), .radio_power_on(radio_power_on), .host_if_en(host_if_en),
        .settings_saved(settings_saved), .hs(hs), .led(led), .req(req)
    );

    task automatic step(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            #1;
        end
    endtask

    task automatic chk(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic chk3(input logic [2:0] got, input logic [2:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    // one-cycle firmware event; returns once the registered answer has landed
    task automatic fw(input int k);
        @(posedge sys_clk);
        fw_in[k] <= 1'b1;
        @(posedge sys_clk);
        fw_in <= 6'h00;
        #1;
    endtask

    task automatic t_reset_values;
        chk(cpu_reset_n, 1'b0, "cpu reset after rst");
        chk(radio_power_on, 1'b0, "radio after rst");
        chk(host_if_en, 1'b0, "interface after rst");
        chk3(hs, 3'h7, "handshakes idle high");
        chk3(led, 3'h7, "indicators dark");
        chk3(req, 3'h0, "requests idle");
    endtask

    task automatic t_forced_hold;
        @(posedge sys_clk);
        cmd_rail  <= 1'b1;
        cmd_on    <= 1'b1;
        cmd_reset <= 1'b1;
        step(RESET_DELAY_CYC + 200);
        chk(cpu_reset_n, 1'b0, "cpu held by forced reset");
        chk(hs.cts_n, 1'b1, "no boot pulse while held");
        @(posedge sys_clk);
        cmd_rail  <= 1'b0;
        cmd_on    <= 1'b0;
        cmd_reset <= 1'b0;
        step(6);
    endtask

    task automatic t_power_up;
        int   n;
        logic lit;
        n   = 0;
        lit = 1'b0;
        @(posedge sys_clk);
        cmd_rail <= 1'b1;
        cmd_on   <= 1'b1;
        while (radio_power_on !== 1'b1 && n < 10) begin
            step(1);
            n++;
        end
        chk(radio_power_on, 1'b1, "radio rail on");
        n = 0;
        while (cpu_reset_n !== 1'b1 && n < 3000) begin
            if (led === 3'h0)
                lit = 1'b1;
            step(1);
            n++;
        end
        chk(n == RESET_DELAY_CYC, 1'b1, "reset delay length");
        chk(lit, 1'b1, "all indicators flash at start");
        chk(hs.cts_n, 1'b0, "boot pulse starts at release");
        n = 0;
        while (hs.cts_n === 1'b0 && n < 100) begin
            step(1);
            n++;
        end
        chk(n == CTS_PULSE_CYC, 1'b1, "boot pulse width");
        step(10);
        chk(hs.cts_n, 1'b1, "clear to send stays off in boot");
        fw(0);
        chk(host_if_en, 1'b0, "interface off before init");
        chk(hs.dsr_n, 1'b1, "no ready before init");
        fw(1);
        chk(host_if_en, 1'b1, "interface on after init");
        chk(hs.dsr_n, 1'b0, "ready after init");
        chk(hs.cts_n, 1'b1, "no clear to send before terminal init");
        chk(hs.dcd_n, 1'b1, "no carrier before ack");
        fw(2);
        chk(hs.cts_n, 1'b0, "clear to send after terminal init");
        chk(hs.dcd_n, 1'b1, "still no carrier");
        fw(3);
        chk(hs.dcd_n, 1'b0, "carrier after ack");
        chk3(led, 3'h7, "indicators dark when ready");
    endtask

    task automatic t_shutdown;
        int         n;
        logic [2:0] seen_lo;
        logic       seen_hi;
        n       = 0;
        seen_lo = 3'h0;
        seen_hi = 1'b0;
        @(posedge sys_clk);
        cmd_on <= 1'b0;
        while (req.dereg_req !== 1'b1 && n < 6) begin
            step(1);
            n++;
        end
        chk(req.dereg_req, 1'b1, "shutdown starts on request drop");
        chk(hs.dsr_n, 1'b0, "ready kept while deregistering");
        repeat (12) begin
            seen_lo |= ~led;
            seen_hi |= led.batt_n;
            step(1);
        end
        chk3(seen_lo, 3'h7, "battery rx tx flash in shutdown");
        chk(seen_hi, 1'b1, "battery indicator toggles");
        chk(hs.dcd_n, 1'b0, "carrier kept until deregistered");
        fw(4);
        chk(hs.dcd_n, 1'b1, "carrier drops after dereg");
        chk(req.save_req, 1'b1, "save follows dereg");
        chk(hs.dsr_n, 1'b0, "ready kept while saving");
        fw(5);
        chk(settings_saved, 1'b1, "settings saved");
        chk(req.save_req, 1'b0, "save request released");
        step(1);
        chk(hs.dsr_n, 1'b1, "ready drops after save");
        chk3(led, 3'h7, "flashing stops when done");
        chk(radio_power_on, 1'b1, "radio still on one cycle");
        step(1);
        chk(radio_power_on, 1'b0, "radio rail off");
        chk(supply_ok, 1'b1, "rail left applied");
    endtask

    task automatic t_cold_start;
        int n;
        n = 0;
        @(posedge sys_clk);
        cmd_reset <= 1'b1;
        while (req.flush_pulse !== 1'b1 && n < 6) begin
            step(1);
            n++;
        end
        chk(req.flush_pulse, 1'b1, "flush on reset after shutdown");
        chk(settings_saved, 1'b0, "saved settings discarded");
        chk(cpu_reset_n, 1'b0, "cpu kept in reset");
        step(1);
        chk(req.flush_pulse, 1'b0, "flush is one cycle");
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        #2_000_000;
        err_count++;
        $display("ERROR t=%0t watchdog expired", $time);
        test_done();
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        step(1);
        t_reset_values();
        t_forced_hold();
        t_power_up();
        t_shutdown();
        t_cold_start();
        test_done();
    end
endmodule
